// >>> verilog/synth_pkg.sv
// Shared constants, types and helpers of the synthesizer control block
package synth_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_VCO       = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CLKOUT    = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_LOCK      = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_DIV_FIRST = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_DIV_LAST  = 4'hb;

  // Field positions
  localparam int CTRL_SLEEP    = 0;
  localparam int CTRL_SET_SEL  = 1;
  localparam int CTRL_LOCK_PIN = 2;
  localparam int VCO_BAND_LSB  = 0;
  localparam int VCO_TUNE_LSB  = 2;
  localparam int VCO_FIELD_W   = 2;
  localparam int CLKOUT_EN     = 0;
  localparam int CLKOUT_DIV_LSB = 1;
  localparam int CLKOUT_DIV_W  = 4;
  localparam int LOCK_FLAG     = 0;
  localparam int LOCK_LIVE     = 1;
  localparam int IRQ_GAINED    = 0;
  localparam int IRQ_LOST      = 1;
  localparam int IRQ_W         = 2;

  // Reset values
  localparam logic [VCO_FIELD_W-1:0]  VCO_BAND_RST   = 2'h2;
  localparam logic [VCO_FIELD_W-1:0]  VCO_TUNE_RST   = 2'h0;
  localparam logic [CLKOUT_DIV_W-1:0] CLKOUT_DIV_RST = 4'h0;

  // Divider bank layout
  localparam int unsigned DIV_WORDS = 6;
  localparam int unsigned DIV_IDX_W = 3;
  localparam logic [DIV_IDX_W-1:0] DIV_SET2_BASE = 3'h3;
  localparam logic [DIV_IDX_W-1:0] DIV_MAIN_OFS  = 3'h1;
  localparam logic [DIV_IDX_W-1:0] DIV_FINE_OFS  = 3'h2;

  // Loop feedback count
  localparam int unsigned FB_W    = 16;
  localparam int unsigned FB_MULT = 75;

  // One complete divider set
  typedef struct packed {
    logic [DATA_W-1:0] ref_div;
    logic [DATA_W-1:0] main_div;
    logic [DATA_W-1:0] fine_div;
  } div_set_t;

  // Feedback count: 75*(main+1)+fine
  function automatic logic [FB_W-1:0] fb_count(input div_set_t s);
    fb_count = FB_W'(FB_MULT) * (FB_W'(s.main_div) + FB_W'(1))
             + FB_W'(s.fine_div);
  endfunction : fb_count

  // Address lies in the divider bank
  function automatic logic is_div_addr(input logic [ADDR_W-1:0] a);
    is_div_addr = (a >= ADDR_DIV_FIRST) && (a <= ADDR_DIV_LAST);
  endfunction : is_div_addr

endpackage : synth_pkg

// >>> verilog/div_bank.sv
// Divider memory with registered read port and active-set output
`timescale 1ns/1ps
`default_nettype none
module div_bank #(
  parameter int unsigned WORDS = synth_pkg::DIV_WORDS
) (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_clk_en,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  input  wire logic                           i_rd_bank,
  input  wire logic [synth_pkg::DIV_IDX_W-1:0] i_idx,
  input  wire logic [synth_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic [synth_pkg::DATA_W-1:0]    i_own_data,
  input  wire logic                           i_sel,
  output logic      [synth_pkg::DATA_W-1:0]    o_rdata,
  output synth_pkg::div_set_t                 o_active
);

  typedef struct packed {
    logic [WORDS-1:0][synth_pkg::DATA_W-1:0] mem;
    logic [synth_pkg::DATA_W-1:0]            rdata;
    synth_pkg::div_set_t                     active;
  } bank_state_t;

  bank_state_t q;
  bank_state_t d;
  logic [synth_pkg::DIV_IDX_W-1:0] base;

  // Writes, read register and set selection
  always_comb begin
    d = q;
    base = i_sel ? synth_pkg::DIV_SET2_BASE : '0;
    if (i_wr) begin
      d.mem[i_idx] = i_wdata;
    end
    d.rdata = '0;
    if (i_rd) begin
      d.rdata = i_rd_bank ? q.mem[i_idx] : i_own_data;
    end
    d.active.ref_div  = q.mem[base];
    d.active.main_div = q.mem[base + synth_pkg::DIV_MAIN_OFS];
    d.active.fine_div = q.mem[base + synth_pkg::DIV_FINE_OFS];
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_rdata  = q.rdata;
  assign o_active = q.active;

endmodule : div_bank
`default_nettype wire

// >>> verilog/clkout_div.sv
// Reference clock output divider
`timescale 1ns/1ps
`default_nettype none
module clkout_div #(
  parameter int unsigned DIV_W = synth_pkg::CLKOUT_DIV_W
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clk_en,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_ratio,
  output logic                  o_clk
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             clk;
  } div_state_t;

  div_state_t q;
  div_state_t d;

  // Half period of ratio+1 cycles, parked low when stopped
  always_comb begin
    d = q;
    if (!i_run) begin
      d.cnt = '0;
      d.clk = 1'b0;
    end else if (q.cnt >= i_ratio) begin
      d.cnt = '0;
      d.clk = ~q.clk;
    end else begin
      d.cnt = q.cnt + DIV_W'(1);
    end
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_clk = q.clk;

endmodule : clkout_div
`default_nettype wire

// >>> verilog/synth_config_lock_clkout.sv
// Synthesizer control: divider sets, VCO fields, lock flag, clock output
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enabled clock output drives divided reference
// - Clock output enabled straight after reset
// - Clock output stops in sleep mode
// - VCO tune step resets to zero
// - Lock flag sticky, cleared by writing one
// - Lock pin shows lock when enabled
// - Two full divider sets are held
// - Divider bytes sit at addresses 6-11
// - Feedback count is 75*(main+1)+fine
module synth_config_lock_clkout (
  input  wire logic                            i_ref_clk,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_clk_en,
  input  wire logic [synth_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [synth_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                            i_wr,
  input  wire logic                            i_rd,
  input  wire logic                            i_pll_lock,
  output logic      [synth_pkg::DATA_W-1:0]    o_rdata,
  output logic                                 o_ref_clk_out,
  output logic                                 o_lock_pin,
  output logic                                 o_irq,
  output logic                                 o_sleep,
  output logic      [synth_pkg::VCO_FIELD_W-1:0] o_vco_band,
  output logic      [synth_pkg::VCO_FIELD_W-1:0] o_vco_tune_step,
  output synth_pkg::div_set_t                  o_synth_div,
  output logic      [synth_pkg::FB_W-1:0]      o_fb_count
);

  typedef struct packed {
    logic                                    sleep;
    logic                                    set_sel;
    logic                                    lock_pin_en;
    logic [synth_pkg::VCO_FIELD_W-1:0]       vco_band;
    logic [synth_pkg::VCO_FIELD_W-1:0]       tune;
    logic                                    clk_on;
    logic [synth_pkg::CLKOUT_DIV_W-1:0]      clk_div;
    logic                                    lock_flag;
    logic [synth_pkg::IRQ_W-1:0]             irq_stat;
    logic [synth_pkg::IRQ_W-1:0]             irq_mask;
    logic                                    sync1;
    logic                                    sync2;
    logic                                    lock_prev;
    logic                                    irq;
    logic                                    lock_pin;
    logic [synth_pkg::FB_W-1:0]              fb;
  } ctl_state_t;

  localparam ctl_state_t CTL_RST = '{
    clk_on:   1'b1,
    vco_band: synth_pkg::VCO_BAND_RST,
    tune:     synth_pkg::VCO_TUNE_RST,
    clk_div:  synth_pkg::CLKOUT_DIV_RST,
    default:  '0
  };

  ctl_state_t q;
  ctl_state_t d;

  logic                                 wr_ctrl;
  logic                                 wr_vco;
  logic                                 wr_clkout;
  logic                                 wr_lock;
  logic                                 wr_mask;
  logic                                 rd_stat;
  logic                                 bank_hit;
  logic                                 lock_rise;
  logic                                 lock_fall;
  logic [synth_pkg::IRQ_W-1:0]          irq_set;
  logic [synth_pkg::DATA_W-1:0]         own_rdata;
  logic [synth_pkg::DIV_IDX_W-1:0]      bank_idx;
  logic [synth_pkg::ADDR_W-1:0]         bank_ofs;
  logic                                 clkout_run;

  // Address decode for the register port
  always_comb begin
    wr_ctrl   = i_wr && (i_addr == synth_pkg::ADDR_CTRL);
    wr_vco    = i_wr && (i_addr == synth_pkg::ADDR_VCO);
    wr_clkout = i_wr && (i_addr == synth_pkg::ADDR_CLKOUT);
    wr_lock   = i_wr && (i_addr == synth_pkg::ADDR_LOCK);
    wr_mask   = i_wr && (i_addr == synth_pkg::ADDR_IRQ_MASK);
    rd_stat   = i_rd && (i_addr == synth_pkg::ADDR_IRQ_STAT);
    bank_hit  = synth_pkg::is_div_addr(i_addr);
    bank_ofs  = i_addr - synth_pkg::ADDR_DIV_FIRST;
    bank_idx  = bank_ofs[synth_pkg::DIV_IDX_W-1:0];
  end

  // Lock edge events from the synchronised lock level
  always_comb begin
    lock_rise = q.sync2 && !q.lock_prev;
    lock_fall = !q.sync2 && q.lock_prev;
    irq_set   = '0;
    irq_set[synth_pkg::IRQ_GAINED] = lock_rise;
    irq_set[synth_pkg::IRQ_LOST]   = lock_fall;
  end

  // Read data of the block's own registers
  always_comb begin
    own_rdata = '0;
    unique case (i_addr)
      synth_pkg::ADDR_CTRL: begin
        own_rdata[synth_pkg::CTRL_SLEEP]    = q.sleep;
        own_rdata[synth_pkg::CTRL_SET_SEL]  = q.set_sel;
        own_rdata[synth_pkg::CTRL_LOCK_PIN] = q.lock_pin_en;
      end
      synth_pkg::ADDR_VCO: begin
        own_rdata[synth_pkg::VCO_BAND_LSB +: synth_pkg::VCO_FIELD_W] =
          q.vco_band;
        own_rdata[synth_pkg::VCO_TUNE_LSB +: synth_pkg::VCO_FIELD_W] =
          q.tune;
      end
      synth_pkg::ADDR_CLKOUT: begin
        own_rdata[synth_pkg::CLKOUT_EN] = q.clk_on;
        own_rdata[synth_pkg::CLKOUT_DIV_LSB +: synth_pkg::CLKOUT_DIV_W] =
          q.clk_div;
      end
      synth_pkg::ADDR_LOCK: begin
        own_rdata[synth_pkg::LOCK_FLAG] = q.lock_flag;
        own_rdata[synth_pkg::LOCK_LIVE] = q.sync2;
      end
      synth_pkg::ADDR_IRQ_STAT: begin
        own_rdata[synth_pkg::IRQ_W-1:0] = q.irq_stat;
      end
      synth_pkg::ADDR_IRQ_MASK: begin
        own_rdata[synth_pkg::IRQ_W-1:0] = q.irq_mask;
      end
      default: begin
        own_rdata = '0;
      end
    endcase
  end

  // Next-state logic of the control state
  always_comb begin
    d = q;
    // Two-flop synchroniser on the PLL lock input
    d.sync1     = i_pll_lock;
    d.sync2     = q.sync1;
    d.lock_prev = q.sync2;
    if (wr_ctrl) begin
      d.sleep       = i_wdata[synth_pkg::CTRL_SLEEP];
      d.set_sel     = i_wdata[synth_pkg::CTRL_SET_SEL];
      d.lock_pin_en = i_wdata[synth_pkg::CTRL_LOCK_PIN];
    end
    if (wr_vco) begin
      d.vco_band = i_wdata[synth_pkg::VCO_BAND_LSB +: synth_pkg::VCO_FIELD_W];
      d.tune = i_wdata[synth_pkg::VCO_TUNE_LSB +: synth_pkg::VCO_FIELD_W];
    end
    if (wr_clkout) begin
      d.clk_on  = i_wdata[synth_pkg::CLKOUT_EN];
      d.clk_div =
        i_wdata[synth_pkg::CLKOUT_DIV_LSB +: synth_pkg::CLKOUT_DIV_W];
    end
    // Sticky lock flag, write one clears, new lock wins
    if (wr_lock && i_wdata[synth_pkg::LOCK_FLAG]) begin
      d.lock_flag = 1'b0;
    end
    if (lock_rise) begin
      d.lock_flag = 1'b1;
    end
    // Interrupt status cleared by read, events win
    if (rd_stat) begin
      d.irq_stat = '0;
    end
    d.irq_stat = d.irq_stat | irq_set;
    if (wr_mask) begin
      d.irq_mask = i_wdata[synth_pkg::IRQ_W-1:0];
    end
    d.irq      = |(d.irq_stat & d.irq_mask);
    d.lock_pin = d.lock_pin_en && q.sync2;
    d.fb       = synth_pkg::fb_count(o_synth_div);
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      q <= CTL_RST;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  // Clock output runs only when enabled and awake
  assign clkout_run = q.clk_on && !q.sleep;

  clkout_div #(
    .DIV_W (synth_pkg::CLKOUT_DIV_W)
  ) u_clkout_div (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_run     (clkout_run),
    .i_ratio   (q.clk_div),
    .o_clk     (o_ref_clk_out)
  );

  // Two divider sets and the read data register
  div_bank #(
    .WORDS (synth_pkg::DIV_WORDS)
  ) u_div_bank (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_clk_en   (i_clk_en),
    .i_wr       (i_wr && bank_hit),
    .i_rd       (i_rd),
    .i_rd_bank  (bank_hit),
    .i_idx      (bank_idx),
    .i_wdata    (i_wdata),
    .i_own_data (own_rdata),
    .i_sel      (q.set_sel),
    .o_rdata    (o_rdata),
    .o_active   (o_synth_div)
  );

  // Outputs from state flops
  assign o_lock_pin      = q.lock_pin;
  assign o_irq           = q.irq;
  assign o_sleep         = q.sleep;
  assign o_vco_band      = q.vco_band;
  assign o_vco_tune_step = q.tune;
  assign o_fb_count      = q.fb;

  // Checks on the block's own behaviour
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n || !i_clk_en);

  clkout_reset_a: assert property (
    !$past(i_rst_n) |-> (q.clk_on && !o_ref_clk_out)
  ) else $error("clock output not enabled after reset");

  clkout_sleep_a: assert property (
    q.sleep |=> !o_ref_clk_out
  ) else $error("clock output running in sleep");

  clkout_toggle_a: assert property (
    (clkout_run && (q.clk_div == '0))[*3]
      |-> (o_ref_clk_out != $past(o_ref_clk_out))
  ) else $error("clock output not toggling at ratio zero");

  tune_reset_a: assert property (
    !$past(i_rst_n) |-> (o_vco_tune_step == synth_pkg::VCO_TUNE_RST)
  ) else $error("tune step not zero after reset");

  lock_set_a: assert property (
    $rose(q.sync2) |=> q.lock_flag
  ) else $error("lock flag not set on lock");

  lock_hold_a: assert property (
    (q.lock_flag && !(wr_lock && i_wdata[synth_pkg::LOCK_FLAG]))
      |=> q.lock_flag
  ) else $error("lock flag dropped without clear");

  lock_clear_a: assert property (
    (wr_lock && i_wdata[synth_pkg::LOCK_FLAG] && !lock_rise)
      |=> !q.lock_flag
  ) else $error("lock flag not cleared by write one");

  lock_pin_a: assert property (
    (!q.lock_pin_en)[*2] |-> !o_lock_pin
  ) else $error("lock pin driven while disabled");

  div_readback_a: assert property (
    (i_wr && bank_hit) ##1 (i_rd && (i_addr == $past(i_addr)))
      |=> (o_rdata == $past(i_wdata, 2))
  ) else $error("divider byte readback mismatch");

  fb_count_a: assert property (
    ($stable(o_synth_div) && $past(i_rst_n))[*2] |-> (o_fb_count ==
      synth_pkg::fb_count(o_synth_div))
  ) else $error("feedback count mismatch");

  set_switch_a: assert property (
    ($changed(q.set_sel) && !i_wr) |=> (o_synth_div.ref_div ==
      (q.set_sel ? u_div_bank.q.mem[synth_pkg::DIV_SET2_BASE]
                 : u_div_bank.q.mem[0]))
  ) else $error("divider set switch late");

  read_once_a: assert property (
    !$past(i_rd) |-> (o_rdata == '0)
  ) else $error("read data outside read answer");

  // Register port checks
  unmapped_read_a: assert property (
    (i_rd && (i_addr > synth_pkg::ADDR_DIV_LAST)) |=> (o_rdata == '0)
  ) else $error("unmapped address read not zero");

  bank_write_a: assert property (
    (i_wr && bank_hit) |=>
      (u_div_bank.q.mem[$past(bank_idx)] == $past(i_wdata))
  ) else $error("divider byte not stored");

  flag_read_a: assert property (
    (i_rd && (i_addr == synth_pkg::ADDR_LOCK)) |=>
      (o_rdata[synth_pkg::LOCK_FLAG] == $past(q.lock_flag))
  ) else $error("lock flag readback mismatch");

  vco_write_a: assert property (
    wr_vco |=> (o_vco_tune_step ==
      $past(i_wdata[synth_pkg::VCO_TUNE_LSB +: synth_pkg::VCO_FIELD_W]))
  ) else $error("tune step write not applied");

  // Clock output and lock pin checks
  clkout_off_a: assert property (
    !q.clk_on |=> !o_ref_clk_out
  ) else $error("clock output running while disabled");

  lock_pin_on_a: assert property (
    (q.lock_pin_en && q.sync2 && !wr_ctrl) |=> o_lock_pin
  ) else $error("lock pin not showing lock");

  // Interrupt status and level
  irq_gain_a: assert property (
    lock_rise |=> q.irq_stat[synth_pkg::IRQ_GAINED]
  ) else $error("lock gained event not recorded");

  irq_loss_a: assert property (
    lock_fall |=> q.irq_stat[synth_pkg::IRQ_LOST]
  ) else $error("lock lost event not recorded");

  irq_hold_a: assert property (
    (q.irq_stat[synth_pkg::IRQ_GAINED] && !rd_stat)
      |=> q.irq_stat[synth_pkg::IRQ_GAINED]
  ) else $error("interrupt status dropped without read");

  irq_clear_a: assert property (
    (rd_stat && !(|irq_set)) |=> (q.irq_stat == '0)
  ) else $error("interrupt status not cleared by read");

  irq_level_a: assert property (
    o_irq == (|(q.irq_stat & q.irq_mask))
  ) else $error("interrupt level out of step");

  lock_seen_c:  cover property ($rose(q.lock_flag));
  sleep_seen_c: cover property (q.sleep && q.clk_on);
  set_swap_c:   cover property ($changed(q.set_sel));
  irq_seen_c:   cover property ($rose(o_irq));
  lock_pin_c:   cover property ($rose(o_lock_pin));

endmodule : synth_config_lock_clkout
`default_nettype wire

// >>> dv/mcu_clk_monitor.sv
// Companion controller model that times the reference clock output
`timescale 1ns/1ps
`default_nettype none
module mcu_clk_monitor (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_out,
  output logic      [7:0]  o_half_cycles,
  output logic      [15:0] o_edges
);
  logic       last_q;
  logic [7:0] cnt_q;

  // Count reference cycles between toggles of the clock output
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      last_q        <= 1'b0;
      cnt_q         <= 8'h01;
      o_half_cycles <= 8'h00;
      o_edges       <= 16'h0000;
    end else if (i_clk_out !== last_q) begin
      last_q        <= i_clk_out;
      o_half_cycles <= cnt_q;
      cnt_q         <= 8'h01;
      o_edges       <= o_edges + 16'h0001;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : mcu_clk_monitor
`default_nettype wire

// >>> dv/synth_config_lock_clkout_tb_top.sv
// Self-checking bench of the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module synth_config_lock_clkout_tb_top;
  logic                           i_ref_clk = 1'b0;
  logic                           i_rst_n   = 1'b0;
  logic                           i_clk_en  = 1'b1;
  logic [synth_pkg::ADDR_W-1:0]   i_addr    = 4'h0;
  logic [synth_pkg::DATA_W-1:0]   i_wdata   = 8'h00;
  logic                           i_wr      = 1'b0;
  logic                           i_rd      = 1'b0;
  logic                           i_pll_lock = 1'b0;
  logic [synth_pkg::DATA_W-1:0]   o_rdata;
  logic                           o_ref_clk_out;
  logic                           o_lock_pin;
  logic                           o_irq;
  logic                           o_sleep;
  logic [1:0]                     o_vco_band;
  logic [1:0]                     o_vco_tune_step;
  synth_pkg::div_set_t            o_synth_div;
  logic [synth_pkg::FB_W-1:0]     o_fb_count;
  logic [7:0]                     half_cycles;
  logic [15:0]                    edges;
  int                             miscompares = 0;
  int                             n_compared  = 0;
  logic [7:0]                     rv;
  // Reference dividers near 119 and inside 64..169, fine below main+1,
  // both sets are FSK values, an OOK set would sit
  // one low IF lower
  logic [7:0]                     divs [6] = '{8'h77, 8'h2a, 8'h10,
                                               8'ha9, 8'h30, 8'h05};

  // 25 MHz reference clock
  always #20 i_ref_clk = ~i_ref_clk;

  synth_config_lock_clkout uut (
    .i_ref_clk       (i_ref_clk),
    .i_rst_n         (i_rst_n),
    .i_clk_en        (i_clk_en),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .i_pll_lock      (i_pll_lock),
    .o_rdata         (o_rdata),
    .o_ref_clk_out   (o_ref_clk_out),
    .o_lock_pin      (o_lock_pin),
    .o_irq           (o_irq),
    .o_sleep         (o_sleep),
    .o_vco_band      (o_vco_band),
    .o_vco_tune_step (o_vco_tune_step),
    .o_synth_div     (o_synth_div),
    .o_fb_count      (o_fb_count)
  );

  mcu_clk_monitor partner (
    .i_ref_clk     (i_ref_clk),
    .i_rst_n       (i_rst_n),
    .i_clk_out     (o_ref_clk_out),
    .o_half_cycles (half_cycles),
    .o_edges       (edges)
  );

  // Compare one value of up to 24 bits
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : cyc

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  // Write then read back in the next cycle, no gap between strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] w,
                       output logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= w;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
    i_rd    <= 1'b1;
    @(posedge i_ref_clk);
    i_rd    <= 1'b0;
    #1;
    d = o_rdata;
  endtask : wr_rd

  // Power-up defaults and free-running clock output
  task automatic t_reset;
    rd(synth_pkg::ADDR_CLKOUT, rv);
    chk(rv, 24'h01);
    rd(synth_pkg::ADDR_VCO, rv);
    chk(rv, 24'h02);
    chk(o_vco_tune_step, 24'h0);
    // Band for the 902-915 MHz channel, tune one step up
    wr(synth_pkg::ADDR_VCO, 8'h04);
    rd(synth_pkg::ADDR_VCO, rv);
    chk(rv, 24'h04);
    chk(o_vco_band, 24'h0);
    chk(o_vco_tune_step, 24'h1);
    cyc(6);
    chk(half_cycles, 24'h01);
    rd(4'hd, rv);
    chk(rv, 24'h00);
    $display("test reset done");
  endtask : t_reset

  // Divide ratios of the clock output
  task automatic t_ratio;
    logic [3:0] r [4] = '{4'h0, 4'h1, 4'h7, 4'hf};
    for (int i = 0; i < 4; i++) begin
      wr(synth_pkg::ADDR_CLKOUT, {3'h0, r[i], 1'b1});
      cyc(8 * (int'(r[i]) + 1));
      chk(half_cycles, {20'h0, r[i]} + 24'h1);
    end
    $display("test ratio done");
  endtask : t_ratio

  // Output stops when disabled or in sleep
  task automatic t_stop;
    logic [15:0] e;
    wr(synth_pkg::ADDR_CLKOUT, 8'h01);
    wr(synth_pkg::ADDR_CTRL, 8'h01);
    cyc(3);
    chk(o_sleep, 24'h1);
    e = edges;
    cyc(40);
    chk(edges, {8'h0, e});
    chk(o_ref_clk_out, 24'h0);
    wr(synth_pkg::ADDR_CTRL, 8'h00);
    cyc(6);
    chk(half_cycles, 24'h01);
    // Clock enable low freezes the output divider
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    cyc(3);
    e = edges;
    cyc(10);
    chk(edges, {8'h0, e});
    @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    cyc(4);
    chk(half_cycles, 24'h01);
    wr(synth_pkg::ADDR_CLKOUT, 8'h00);
    cyc(3);
    e = edges;
    cyc(20);
    chk(edges, {8'h0, e});
    chk(o_ref_clk_out, 24'h0);
    wr(synth_pkg::ADDR_CLKOUT, 8'h01);
    $display("test stop done");
  endtask : t_stop

  // Two divider sets, readback and selection
  task automatic t_divs;
    logic [15:0] fb;
    for (int i = 0; i < 6; i++) wr(4'(6 + i), divs[i]);
    for (int i = 0; i < 6; i++) begin
      rd(4'(6 + i), rv);
      chk(rv, {16'h0, divs[i]});
    end
    // Back-to-back write and read of one divider byte
    wr_rd(synth_pkg::ADDR_DIV_FIRST, 8'h78, rv);
    chk(rv, 24'h78);
    wr_rd(synth_pkg::ADDR_DIV_FIRST, divs[0], rv);
    chk(rv, {16'h0, divs[0]});
    for (int s = 0; s < 2; s++) begin
      wr(synth_pkg::ADDR_CTRL, {6'h0, 1'(s), 1'b0});
      cyc(4);
      chk(o_synth_div, {divs[3*s], divs[3*s+1], divs[3*s+2]});
      fb = 16'd75 * (16'(divs[3*s+1]) + 16'd1) + 16'(divs[3*s+2]);
      chk(o_fb_count, {8'h0, fb});
    end
    wr(synth_pkg::ADDR_CTRL, 8'h00);
    cyc(1);
    chk(o_synth_div, {divs[0], divs[1], divs[2]});
    $display("test dividers done");
  endtask : t_divs

  // Sticky lock flag, lock pin and interrupt
  task automatic t_lock;
    wr(synth_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(synth_pkg::ADDR_CTRL, 8'h04);
    @(posedge i_ref_clk);
    i_pll_lock <= 1'b1;
    cyc(6);
    chk(o_lock_pin, 24'h1);
    chk(o_irq, 24'h1);
    @(posedge i_ref_clk);
    i_pll_lock <= 1'b0;
    cyc(6);
    chk(o_lock_pin, 24'h0);
    rd(synth_pkg::ADDR_LOCK, rv);
    chk(rv, 24'h01);
    rd(synth_pkg::ADDR_IRQ_STAT, rv);
    chk(rv, 24'h03);
    cyc(2);
    chk(o_irq, 24'h0);
    wr(synth_pkg::ADDR_LOCK, 8'h01);
    rd(synth_pkg::ADDR_LOCK, rv);
    chk(rv, 24'h00);
    $display("test lock done");
  endtask : t_lock

  // Verdict and end of run
  task automatic results;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Watchdog well beyond the expected run length
  initial begin
    #(20000 * 40);
    miscompares++;
    results();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_ratio();
    t_stop();
    t_divs();
    t_lock();
    results();
  end
endmodule : synth_config_lock_clkout_tb_top
`default_nettype wire
